// file: ptm_map.svh
// Constants of the periodic timer: counter limits and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH

// ---------------------------------------------------------------------
// Counter limits
// ---------------------------------------------------------------------
`define PTM_CNT_W_NARROW 10
`define PTM_CNT_W_WIDE   16
`define PTM_CNT_MAX_10   16'h03ff
`define PTM_CNT_MAX_16   16'hffff

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define PTM_CNT_RST      16'h0000
`define PTM_FLAG_RST     1'b0
`define PTM_RUN_RST      1'b0
`define PTM_PIN_RST      1'b0
`define PTM_OE_RST       1'b0

`endif

// file: ptm_pkg.sv
// Types shared by the periodic timer core and its trigger synchroniser.
// Assumes ptm_map.svh sits in the same folder.
`include "ptm_map.svh"

package ptm_pkg;

   // ------------------------------------------------------------------
   // Mode and pin-action encodings
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      PTM_MODE_CMP = 2'b00,
      PTM_MODE_CAP = 2'b01,
      PTM_MODE_PWM = 2'b10,
      PTM_MODE_TMR = 2'b11
   } ptm_mode_t;

   typedef enum logic [1:0] {
      PTM_IO_NONE = 2'b00,
      PTM_IO_LOW  = 2'b01,
      PTM_IO_HIGH = 2'b10,
      PTM_IO_TOG  = 2'b11
   } ptm_io_t;

   // ------------------------------------------------------------------
   // Control carrier and state records
   // ------------------------------------------------------------------
   typedef struct packed {
      ptm_mode_t op_mode_select;
      ptm_io_t   output_action_select;
      logic      output_initial_level;
      logic      output_invert;
      logic      counter_clear_select;
      logic      trigger_falling;
   } ptm_cfg_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic        run;
      logic        run_prev;
      logic        pin_lvl;
      logic        flag_a;
      logic        flag_p;
      logic        pin;
      logic        oe;
   } ptm_state_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
      logic fall;
   } ptm_sync_state_t;

endpackage : ptm_pkg

// file: ptm_trig_sync.sv
// Three-stage synchroniser with edge pulses for the external trigger pin.
// Assumes the pin is asynchronous to i_clock; pulses last one cycle.
`timescale 1ns/10ps

module ptm_trig_sync (
   input  wire logic i_clock,
   input  wire logic i_arst_n,
   input  wire logic i_pin,
   output logic      o_rise,
   output logic      o_fall
);

   ptm_pkg::ptm_sync_state_t st_ff;
   ptm_pkg::ptm_sync_state_t nxt_st;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.s1   = i_pin;
      nxt_st.s2   = st_ff.s1;
      nxt_st.s3   = st_ff.s2;
      nxt_st.rise = 1'b0;
      nxt_st.fall = 1'b0;
      // A change counts only once the two settled stages agree
      if ((st_ff.s2 == st_ff.s3) && (st_ff.s3 != st_ff.level)) begin
         nxt_st.level = st_ff.s3;
         nxt_st.rise  = st_ff.s3;
         nxt_st.fall  = ~st_ff.s3;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_rise = st_ff.rise;
   assign o_fall = st_ff.fall;

endmodule : ptm_trig_sync

// file: ptm_core.sv
// Periodic timer: counter, two comparators, match flags, one output pin.
// Assumes i_tick is a one-cycle enable from the timer clock divider and
// that software drives the configuration and the counter_run writes.
//
// Behaviour
// - counter_clear_select high clears counter on compare A match.
// - compare mode pin changes only on match A and on run rise, never on period match.
// - compare and single pulse: each rise of counter_run restores pin to output_initial_level.
// - counter maximum is 0x3FF (10-bit) or 0xFFFF (16-bit), then wraps.
// - counter_clear_select high suppresses match_p_flag outside PWM mode.
// - mode 11 counts and flags like compare mode, pin not driven.
// - PWM mode ignores counter_clear_select.
// - PWM period match clears counter; compare A sets duty.
// - PWM raises match_a_flag and match_p_flag on their matches.
// - 10-bit PWM period equals period value, zero gives 1024.
// - 16-bit PWM period equals period value, zero gives 65536.
// - compare A at or above period gives 100 percent duty.
// - PWM polarity from initial level, inverted by invert, forced by io.
// - PWM counting and flags continue while io is 00 or 01.
// - single pulse: counter_run rise starts counter and leading edge.
// - single pulse: trigger pin active edge sets counter_run.
// - pulse ends on software clear or match A, which clears run.
// - single pulse ending match A raises the interrupt request flag.
// - single pulse: counter zeroed only on run rise; period unused.
// - clear select low clears on period match, or overflow if zero.
// - compare mode io drives high, low or toggles; 00 no change.
// - compare A zero: match_a_flag stays low; with clear select high the counter overflows.
// - output_invert inverts the pin, no effect in capture or timer mode.
`timescale 1ns/10ps
`include "ptm_map.svh"

module ptm_core #(
   parameter int CNT_W = `PTM_CNT_W_NARROW
) (
   input  wire logic              i_clock,
   input  wire logic              i_arst_n,
   input  wire logic              i_tick,
   input  wire ptm_pkg::ptm_cfg_t i_cfg,
   input  wire logic [CNT_W-1:0]  i_compare_a_value,
   input  wire logic [CNT_W-1:0]  i_period_compare_value,
   input  wire logic              i_run_wr,
   input  wire logic              i_run_wdata,
   input  wire logic              i_flag_a_clear,
   input  wire logic              i_flag_p_clear,
   input  wire logic              i_ext_trigger_pin,
   output logic [CNT_W-1:0]       o_count,
   output logic                   o_counter_run,
   output logic                   o_match_a_flag,
   output logic                   o_match_p_flag,
   output logic                   o_pin,
   output logic                   o_pin_oe
);

   // ------------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------------
   generate
      if ((CNT_W != `PTM_CNT_W_NARROW) && (CNT_W != `PTM_CNT_W_WIDE))
      begin : g_bad_width
         $error("ptm_core: CNT_W must be 10 or 16");
      end
   endgenerate

   // Counter limit for this instance width
   localparam logic [15:0] CNT_MASK = (CNT_W == `PTM_CNT_W_WIDE) ?
                                      `PTM_CNT_MAX_16 : `PTM_CNT_MAX_10;

   // ------------------------------------------------------------------
   // Trigger pin synchroniser
   // ------------------------------------------------------------------
   logic trig_rise;
   logic trig_fall;

   ptm_trig_sync ptm_trig_sync_inst (
      .i_clock  (i_clock),
      .i_arst_n (i_arst_n),
      .i_pin    (i_ext_trigger_pin),
      .o_rise   (trig_rise),
      .o_fall   (trig_fall)
   );

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   ptm_pkg::ptm_state_t st_ff;
   ptm_pkg::ptm_state_t nxt_st;

   logic [15:0] compare_a_value;
   logic [15:0] period_compare_value;
   logic [15:0] inc;
   logic        single;
   logic        run_rise;
   logic        counting;
   logic        a_hit;
   logic        p_hit;
   logic        clr_hit;
   logic        trig_edge;
   logic        pwm_active;
   logic        base;

   assign compare_a_value = 16'(i_compare_a_value);
   assign period_compare_value = 16'(i_period_compare_value);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      nxt_st      = st_ff;
      pwm_active  = 1'b0;
      base        = 1'b0;
      clr_hit     = 1'b0;

      single   = (i_cfg.op_mode_select == ptm_pkg::PTM_MODE_PWM) &&
                 (i_cfg.output_action_select == ptm_pkg::PTM_IO_TOG);
      run_rise = st_ff.run & ~st_ff.run_prev;
      counting = i_tick & st_ff.run & ~run_rise;
      // Wraps past the width maximum, which doubles as overflow
      inc      = (st_ff.cnt + 16'h0001) & CNT_MASK;
      // A zero compare A value never matches
      a_hit    = counting && (inc == compare_a_value) && (compare_a_value != 16'h0000);
      // A zero period value matches at the wrap to zero
      p_hit    = counting && (inc == period_compare_value);
      trig_edge = i_cfg.trigger_falling ? trig_fall : trig_rise;

      nxt_st.run_prev = st_ff.run;

      // Software write of counter_run, then hardware set and clear
      if (i_run_wr) begin
         nxt_st.run = i_run_wdata;
      end
      if (single && trig_edge) begin
         nxt_st.run = 1'b1;
      end

      // Flag clears first so that a same-cycle set wins
      if (i_flag_a_clear) begin
         nxt_st.flag_a = 1'b0;
      end
      if (i_flag_p_clear) begin
         nxt_st.flag_p = 1'b0;
      end

      // Counting and matches
      if (run_rise) begin
         nxt_st.pin_lvl = i_cfg.output_initial_level;
         if (single) begin
            nxt_st.cnt = `PTM_CNT_RST;
         end
      end else if (counting) begin
         case (i_cfg.op_mode_select)
            ptm_pkg::PTM_MODE_PWM: begin
               if (single) begin
                  // Counter only wraps; period value is not looked at
                  nxt_st.cnt = inc;
                  if (a_hit) begin
                     nxt_st.flag_a = 1'b1;
                     nxt_st.run    = 1'b0;
                  end
               end else begin
                  // Clear select is ignored; period match sets period
                  nxt_st.cnt = p_hit ? `PTM_CNT_RST : inc;
                  if (a_hit) begin
                     nxt_st.flag_a = 1'b1;
                  end
                  if (p_hit) begin
                     nxt_st.flag_p = 1'b1;
                  end
               end
            end
            default: begin
               // Compare, capture and timer modes count alike
               clr_hit = i_cfg.counter_clear_select ? a_hit : p_hit;
               nxt_st.cnt = clr_hit ? `PTM_CNT_RST : inc;
               if (a_hit) begin
                  nxt_st.flag_a = 1'b1;
               end
               if (p_hit && !i_cfg.counter_clear_select) begin
                  nxt_st.flag_p = 1'b1;
               end
               if (a_hit &&
                   (i_cfg.op_mode_select == ptm_pkg::PTM_MODE_CMP)) begin
                  case (i_cfg.output_action_select)
                     ptm_pkg::PTM_IO_LOW:  nxt_st.pin_lvl = 1'b0;
                     ptm_pkg::PTM_IO_HIGH: nxt_st.pin_lvl = 1'b1;
                     ptm_pkg::PTM_IO_TOG:  nxt_st.pin_lvl = ~st_ff.pin_lvl;
                     default:              nxt_st.pin_lvl = st_ff.pin_lvl;
                  endcase
               end
            end
         endcase
      end

      // Pin level, aligned with the counter value just computed
      // Duty at or above the period keeps the wave active throughout
      pwm_active = (nxt_st.cnt < compare_a_value);
      case (i_cfg.op_mode_select)
         ptm_pkg::PTM_MODE_CMP: begin
            base      = nxt_st.pin_lvl;
            nxt_st.oe = 1'b1;
         end
         ptm_pkg::PTM_MODE_PWM: begin
            nxt_st.oe = 1'b1;
            case (i_cfg.output_action_select)
               ptm_pkg::PTM_IO_NONE: base = ~i_cfg.output_initial_level;
               ptm_pkg::PTM_IO_LOW:  base = i_cfg.output_initial_level;
               ptm_pkg::PTM_IO_HIGH: base = pwm_active ?
                                            i_cfg.output_initial_level :
                                            ~i_cfg.output_initial_level;
               default:              base = nxt_st.run ?
                                            i_cfg.output_initial_level :
                                            ~i_cfg.output_initial_level;
            endcase
         end
         default: begin
            // Pin left to other functions
            base      = 1'b0;
            nxt_st.oe = 1'b0;
         end
      endcase
      nxt_st.pin = nxt_st.oe ? (base ^ i_cfg.output_invert) :
                               1'b0;
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_ff <= '{cnt:      `PTM_CNT_RST,
                    run:      `PTM_RUN_RST,
                    run_prev: `PTM_RUN_RST,
                    pin_lvl:  `PTM_PIN_RST,
                    flag_a:   `PTM_FLAG_RST,
                    flag_p:   `PTM_FLAG_RST,
                    pin:      `PTM_PIN_RST,
                    oe:       `PTM_OE_RST};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign o_count        = st_ff.cnt[CNT_W-1:0];
   assign o_counter_run  = st_ff.run;
   assign o_match_a_flag = st_ff.flag_a;
   assign o_match_p_flag = st_ff.flag_p;
   assign o_pin          = st_ff.pin;
   assign o_pin_oe       = st_ff.oe;

endmodule : ptm_core

// file: ptm_core_monitor.sv
// Port-level checker for the periodic timer core.
// Assumes it is bound to ptm_core and sees only that module's ports.
`timescale 1ns/10ps
module ptm_monitor #(
   parameter int CNT_W = 10
) (
   input wire logic              i_clock,
   input wire logic              i_arst_n,
   input wire logic              i_tick,
   input wire ptm_pkg::ptm_cfg_t i_cfg,
   input wire logic [CNT_W-1:0]  i_compare_a_value,
   input wire logic [CNT_W-1:0]  i_period_compare_value,
   input wire logic [CNT_W-1:0]  o_count,
   input wire logic              o_counter_run,
   input wire logic              o_match_a_flag,
   input wire logic              o_match_p_flag,
   input wire logic              o_pin,
   input wire logic              o_pin_oe
);
   // ------
   // Helpers
   // ------
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   logic [CNT_W:0] cnt_inc;
   logic           pwm;
   logic           sp;
   logic           cmp;
   // Unmasked so that a zero compare value can never match at wrap
   assign cnt_inc = {1'b0, o_count} + 1'b1;
   assign pwm = i_cfg.op_mode_select == ptm_pkg::PTM_MODE_PWM;
   assign sp = pwm && i_cfg.output_action_select == ptm_pkg::PTM_IO_TOG;
   assign cmp = i_cfg.op_mode_select == ptm_pkg::PTM_MODE_CMP;
   sequence s_live;
      o_counter_run && $past(o_counter_run) && i_tick;
   endsequence
   property p_hold; !o_counter_run |=> $stable(o_count); endproperty
   property p_step; s_live ##0 !sp |=>
      o_count == $past(cnt_inc[CNT_W-1:0]) || o_count == '0; endproperty
   property p_no_pf; i_cfg.counter_clear_select && !pwm && !o_match_p_flag
      |=> !o_match_p_flag; endproperty
   property p_no_af; i_compare_a_value == '0 && !pwm && !o_match_a_flag
      |=> !o_match_a_flag; endproperty
   property p_tmr; i_cfg.op_mode_select[0] |=> !o_pin_oe && !o_pin;
   endproperty
   property p_restore; cmp && $rose(o_counter_run) |=> o_pin ==
      $past(i_cfg.output_initial_level ^ i_cfg.output_invert); endproperty
   property p_only_a; $past(cmp) && $past(i_cfg) == $past(i_cfg, 2) &&
      $past(o_counter_run, 2) && o_pin != $past(o_pin) |-> o_match_a_flag;
   endproperty
   property p_sp_zero; sp && $rose(o_counter_run) |=> o_count == '0;
   endproperty
   property p_sp_end; s_live ##0 (sp && cnt_inc == {1'b0, i_compare_a_value})
      |=> !o_counter_run && o_match_a_flag; endproperty
   property p_period; s_live ##0 (pwm && !sp && i_period_compare_value ==
      cnt_inc[CNT_W-1:0]) |=> o_count == '0 && o_match_p_flag; endproperty
   property p_force; pwm && !i_cfg.output_action_select[1] |=> o_pin ==
      $past(i_cfg.output_initial_level ^ i_cfg.output_invert ^
      !i_cfg.output_action_select[0]); endproperty
   a_hold: assert property (p_hold) else $error("count moved");
   a_step: assert property (p_step) else $error("bad step");
   a_no_pf: assert property (p_no_pf) else $error("p flag set");
   a_no_af: assert property (p_no_af) else $error("a flag set");
   a_tmr: assert property (p_tmr) else $error("pin driven");
   a_restore: assert property (p_restore) else $error("no restore");
   a_only_a: assert property (p_only_a) else $error("pin moved");
   a_sp_zero: assert property (p_sp_zero) else $error("no zero");
   a_sp_end: assert property (p_sp_end) else $error("no end");
   a_period: assert property (p_period) else $error("period");
   a_force: assert property (p_force) else $error("forced pin");
endmodule : ptm_monitor

bind ptm_core ptm_monitor #(.CNT_W(CNT_W)) ptm_monitor_inst (
   .i_clock(i_clock), .i_arst_n(i_arst_n), .i_tick(i_tick), .i_cfg(i_cfg),
   .i_compare_a_value(i_compare_a_value), .o_pin(o_pin),
   .i_period_compare_value(i_period_compare_value), .o_count(o_count),
   .o_counter_run(o_counter_run), .o_match_a_flag(o_match_a_flag),
   .o_match_p_flag(o_match_p_flag), .o_pin_oe(o_pin_oe));

// file: ptm_pin_partner.sv
// Far side of the timer: trigger source and the loaded output pin.
// Assumes a pull-down on the pin while the timer releases it.
`timescale 1ns/10ps
module ptm_pin_partner (
   input  wire logic i_clock,
   input  wire logic i_pin,
   input  wire logic i_pin_oe,
   output logic      o_level,
   output logic      o_trigger
);
   assign o_level = i_pin_oe ? i_pin : 1'b0;
   initial o_trigger = 1'b0;
   // Low long enough to settle, then a clean rising edge that stays up
   task automatic fire();
      @(posedge i_clock);
      #1 o_trigger = 1'b0;
      repeat (4) @(posedge i_clock);
      #1 o_trigger = 1'b1;
   endtask : fire
endmodule : ptm_pin_partner

// file: ptm_core_tb.sv
// Self-checking bench for the periodic timer core, 10-bit instance.
// Assumes the package, the core and the pin partner are compiled first.
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
   fails++; $display("wrong value %s exp %h got %h", n, e, a); end end
module ptm_core_tb;
   logic              i_clock;
   logic              i_arst_n;
   logic              i_tick;
   logic              run_wr;
   logic              run_wd;
   logic              clr_a;
   logic              clr_p;
   logic              trig;
   ptm_pkg::ptm_cfg_t cfg;
   logic [9:0]        cmp_a;
   logic [9:0]        per_p;
   logic [9:0]        count;
   logic              run;
   logic              flag_a;
   logic              flag_p;
   logic              pin;
   logic              pin_oe;
   logic              pin_w;
   int                fails;
   int                checks_done;
   ptm_core #(.CNT_W(10)) ptm_core_inst (
      .i_clock(i_clock), .i_arst_n(i_arst_n), .i_tick(i_tick), .i_cfg(cfg),
      .i_compare_a_value(cmp_a), .i_period_compare_value(per_p),
      .i_run_wr(run_wr), .i_run_wdata(run_wd), .i_flag_a_clear(clr_a),
      .i_flag_p_clear(clr_p), .i_ext_trigger_pin(trig), .o_count(count),
      .o_counter_run(run), .o_match_a_flag(flag_a), .o_match_p_flag(flag_p),
      .o_pin(pin), .o_pin_oe(pin_oe));
   ptm_pin_partner ptm_pin_partner_inst (.i_clock(i_clock), .i_pin(pin),
      .i_pin_oe(pin_oe), .o_level(pin_w), .o_trigger(trig));
   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end
   // ------
   // Drivers
   // ------
   task automatic cyc(int n = 1);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : cyc
   task automatic set(logic [1:0] m, logic [1:0] io, logic oc, logic cs);
      cfg = {m, io, oc, 1'h0, cs, 1'h0};
   endtask : set
   task automatic run_set(logic v);
      {run_wr, run_wd} = {1'b1, v};
      cyc();
      run_wr = 1'b0;
      cyc(2);
   endtask : run_set
   task automatic tk(int n);
      i_tick = 1'b1;
      cyc(n);
      i_tick = 1'b0;
   endtask : tk
   task automatic clr();
      {clr_a, clr_p} = 2'h3;
      cyc();
      {clr_a, clr_p} = 2'h0;
   endtask : clr
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   // ------
   // Scenarios
   // ------
   task automatic t_cmp();
      logic [1:0] io_seq [3] = '{2'h1, 2'h2, 2'h0};
      set(2'h0, 2'h3, 1'h1, 1'h0);
      {cmp_a, per_p} = {10'h003, 10'h005};
      run_set(1'h1);
      `CHK("restored pin", 1'h1, pin_w)
      clr();
      tk(3);
      `CHK("count", 10'h003, count)
      `CHK("toggled pin", 1'h0, pin_w)
      tk(2);
      `CHK("period clear", 10'h000, count)
      `CHK("flag p", 1'h1, flag_p)
      `CHK("pin on p", 1'h0, pin_w)
      {cmp_a, per_p} = {10'h004, 10'h002};
      clr();
      foreach (io_seq[i]) begin
         set(2'h0, io_seq[i], 1'h0, 1'h1);
         tk(4);
         `CHK("pin action", io_seq[i] != 2'h1, pin_w)
      end
      `CHK("a clear", 10'h000, count)
      `CHK("flag a", 1'h1, flag_a)
      `CHK("no flag p", 1'h0, flag_p)
   endtask : t_cmp
   task automatic t_tmr();
      set(2'h3, 2'h3, 1'h1, 1'h0);
      clr();
      tk(2);
      `CHK("tmr flag p", 1'h1, flag_p)
      `CHK("tmr oe", 1'h0, pin_oe)
      tk(1);
      run_set(1'h0);
      tk(3);
      `CHK("held count", 10'h001, count)
      {cmp_a, per_p} = {10'h000, 10'h000};
      set(2'h0, 2'h0, 1'h0, 1'h0);
      clr();
      run_set(1'h1);
      tk(1022);
      `CHK("max count", 10'h3ff, count)
      `CHK("early p", 1'h0, flag_p)
      tk(1);
      `CHK("overflow", 10'h000, count)
      `CHK("ovf flag p", 1'h1, flag_p)
      `CHK("no flag a", 1'h0, flag_a)
   endtask : t_tmr
   task automatic t_pwm();
      logic [9:0] da [4] = '{10'h001, 10'h004, 10'h006, 10'h002};
      logic       dv [4] = '{1'h0, 1'h0, 1'h1, 1'h1};
      logic [2:0] dh [4] = '{3'h1, 3'h4, 3'h0, 3'h2};
      logic [2:0] hi;
      set(2'h2, 2'h2, 1'h1, 1'h1);
      {cmp_a, per_p} = {10'h001, 10'h004};
      clr();
      tk(4);
      `CHK("pwm clear", 10'h000, count)
      `CHK("pwm flag a", 1'h1, flag_a)
      `CHK("pwm flag p", 1'h1, flag_p)
      for (int i = 0; i < 4; i++) begin
         {cmp_a, cfg.output_invert} = {da[i], dv[i]};
         tk(4);
         hi = 3'h0;
         i_tick = 1'b1;
         repeat (4) begin
            cyc();
            hi += pin_w;
         end
         i_tick = 1'b0;
         `CHK("duty", dh[i], hi)
      end
      per_p = 10'h000;
      clr();
      tk(1023);
      `CHK("long period", 1'h0, flag_p)
      tk(1);
      `CHK("1024 wrap", 1'h1, flag_p)
      {per_p, cfg.output_invert} = {10'h004, 1'h0};
      for (int i = 0; i < 2; i++) begin
         cfg.output_action_select = ptm_pkg::ptm_io_t'(i[1:0]);
         clr();
         tk(4);
         `CHK("forced pin", i[0], pin_w)
         `CHK("still flags", 1'h1, flag_p)
      end
   endtask : t_pwm
   task automatic t_sp();
      run_set(1'h0);
      set(2'h2, 2'h3, 1'h1, 1'h0);
      {cmp_a, per_p} = {10'h003, 10'h001};
      clr();
      run_set(1'h1);
      `CHK("lead edge", 1'h1, pin_w)
      tk(2);
      `CHK("no period", 10'h002, count)
      tk(1);
      cyc();
      `CHK("self stop", 1'h0, run)
      `CHK("sp irq", 1'h1, flag_a)
      `CHK("trail edge", 1'h0, pin_w)
      ptm_pin_partner_inst.fire();
      for (int i = 0; i < 12 && run !== 1'h1; i++) cyc();
      `CHK("trig run", 1'h1, run)
      cyc(2);
      `CHK("restart", 10'h000, count)
      `CHK("trig pulse", 1'h1, pin_w)
      run_set(1'h0);
      `CHK("sw end", 1'h0, pin_w)
      cfg.trigger_falling = 1'b1;
      ptm_pin_partner_inst.fire();
      for (int i = 0; i < 12 && run !== 1'h1; i++) cyc();
      `CHK("fall trig run", 1'h1, run)
   endtask : t_sp
   initial begin
      {i_arst_n, i_tick, run_wr, run_wd, clr_a, clr_p} = 6'h00;
      {cfg, cmp_a, per_p} = {8'h00, 10'h000, 10'h000};
      {fails, checks_done} = {32'h0, 32'h0};
      cyc(16);
      i_arst_n = 1'b1;
      cyc();
      t_cmp();
      t_tmr();
      t_pwm();
      t_sp();
      conclude();
   end
   initial begin
      cyc(6000);
      fails++;
      conclude();
   end
endmodule : ptm_core_tb
